/* File: logic/spsl_fifo.sv */
module spsl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers wrap by hand so DEPTH need not be a power of two
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end

endmodule : spsl_fifo

/* File: logic/spsl_pkg.sv */
package spsl_pkg;

  typedef struct packed {
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } spsl_cmd_t;

  typedef enum logic {
    SPSL_PIN_DOUT,
    SPSL_PIN_OSC
  } spsl_pin_mode_t;

endpackage : spsl_pkg

/* File: logic/spsl_regs.svh */
`ifndef SPSL_REGS_SVH
`define SPSL_REGS_SVH

// Command word layout: bit 15 read flag, 14..8 address, 7..0 data
`define SPSL_WORD_BITS      16
`define SPSL_CMD_READ_BIT   15
`define SPSL_PORT_ADDR_LAST 7'h09
`define SPSL_CFG_ADDR       7'h10
`define SPSL_CFG_RUN_BIT    0
`define SPSL_CFG_PIN_BIT    1
`define SPSL_FIFO_DEPTH     16
`define SPSL_NUM_PORTS      10

`endif

/* File: logic/spsl_top.sv */
`include "spsl_regs.svh"

// How it works
// (R1) Each serial clock rise with select low shifts data input into 16-bit register.
// (R2) Serial data output changes only on serial clock falling edges.
// (R3) Serial clock edges are ignored while chip select is high.
// (R4) Chip select rise latches the last 16 shifted bits as one command.
// (R5) Each input bit appears at the data output 15.5 serial clocks later.
// (R6) Host supplies an external PWM clock no faster than 100 kHz.
// (R7) Dual-function pin works as data output or PWM clock input by config.
// (R8) Power-up pin function is fixed per variant by a parameter.
// (R9) After power-up all ten ports are high impedance until programmed.
// (R10) The block leaves power-up in shutdown.
// (R11) Host selects data output mode when reading ports or checking writes.
// (R12) Clearing the config run bit enters shutdown; setting it leaves shutdown.
// (R13) Each chip select rise while the queue has room hands exactly one latched word to register logic; a full queue drops it.
module spsl_top
  import spsl_pkg::*;
#(
  parameter bit OSC_DEFAULT = 1'b0,
  parameter int WORD_BITS   = `SPSL_WORD_BITS,
  parameter int FIFO_DEPTH  = `SPSL_FIFO_DEPTH,
  parameter int NUM_PORTS   = `SPSL_NUM_PORTS
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_sclk,
  input  wire logic                 i_cs_n,
  input  wire logic                 i_din,
  input  wire logic                 i_dual_function_pin,
  output logic                      o_dual_function_pin,
  output logic                      o_dual_function_pin_oe,
  output logic                      o_pwm_clock_tick,
  output logic                      o_cmd_valid,
  input  wire logic                 i_cmd_ready,
  output spsl_cmd_t                 o_cmd,
  output logic                      o_cmd_room,
  output logic                      o_shutdown,
  output logic      [NUM_PORTS-1:0] o_io_ports_hiz
);

  // Synchronisers: stage 0 is read only by stage 1
  logic [2:0]           sclk_sync_reg;
  logic [2:0]           cs_sync_reg;
  logic [1:0]           din_sync_reg;
  logic [2:0]           osc_sync_reg;

  logic                 sclk_rise;
  logic                 sclk_fall;
  logic                 cs_n_s;
  logic                 cs_rise;
  logic                 din_s;

  logic [WORD_BITS-1:0] shift_reg;
  logic                 dout_reg;
  spsl_pin_mode_t       pin_mode_reg;
  logic                 shutdown_reg;
  logic [NUM_PORTS-1:0] hiz_reg;
  logic                 tick_reg;

  logic                 fifo_in_ready;
  logic [WORD_BITS-1:0] fifo_out_data;
  logic                 cmd_fire;
  logic                 cfg_write;

  function automatic logic is_write_to(input spsl_cmd_t c, input logic [6:0] a);
    return !c.rd && (c.addr == a);
  endfunction : is_write_to

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 3'h7;
      din_sync_reg  <= 2'h0;
      osc_sync_reg  <= 3'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], i_sclk};
      cs_sync_reg   <= {cs_sync_reg[1:0], i_cs_n};
      din_sync_reg  <= {din_sync_reg[0], i_din};
      osc_sync_reg  <= {osc_sync_reg[1:0], i_dual_function_pin};
    end
  end

  assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
  assign sclk_fall = !sclk_sync_reg[1] && sclk_sync_reg[2];
  assign cs_n_s    = cs_sync_reg[1];
  assign cs_rise   = cs_sync_reg[1] && !cs_sync_reg[2];
  assign din_s     = din_sync_reg[1];

  // Older bits simply fall off the top, so only the last word survives
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      shift_reg <= '0;
    end else if (sclk_rise && !cs_n_s) begin // (R3)
      shift_reg <= {shift_reg[WORD_BITS-2:0], din_s}; // (R1)
    end
  end

  // Top bit goes out half a clock after it arrives there
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      dout_reg <= 1'b0;
    end else if (sclk_fall && !cs_n_s) begin // (R3)
      dout_reg <= shift_reg[WORD_BITS-1]; // (R2) (R5)
    end
  end

  // Commands are queued; a full queue drops the word, o_cmd_room warns the host
  spsl_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (cs_rise), // (R4) (R13)
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (shift_reg),
    .o_out_valid (o_cmd_valid),
    .i_out_ready (i_cmd_ready),
    .o_out_data  (fifo_out_data)
  );

  assign o_cmd      = spsl_cmd_t'(fifo_out_data);
  assign o_cmd_room = fifo_in_ready;
  assign cmd_fire   = o_cmd_valid && i_cmd_ready;
  assign cfg_write  = cmd_fire && is_write_to(o_cmd, `SPSL_CFG_ADDR);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      pin_mode_reg <= OSC_DEFAULT ? SPSL_PIN_OSC : SPSL_PIN_DOUT; // (R8)
    end else if (cfg_write) begin
      pin_mode_reg <= o_cmd.data[`SPSL_CFG_PIN_BIT] ? SPSL_PIN_OSC : SPSL_PIN_DOUT; // (R7)
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      shutdown_reg <= 1'b1; // (R10)
    end else if (cfg_write) begin
      shutdown_reg <= !o_cmd.data[`SPSL_CFG_RUN_BIT]; // (R12)
    end
  end

  // A port leaves high impedance only once its own register is written
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      hiz_reg <= '1; // (R9)
    end else if (cmd_fire && !o_cmd.rd && (o_cmd.addr <= `SPSL_PORT_ADDR_LAST)) begin
      hiz_reg[o_cmd.addr[3:0]] <= 1'b0; // (R9)
    end
  end

  // Pulse per external PWM clock rise; the host keeps it no faster than 100 kHz
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (pin_mode_reg == SPSL_PIN_OSC) && osc_sync_reg[1] && !osc_sync_reg[2]; // (R6)
    end
  end

  assign o_dual_function_pin    = dout_reg;
  assign o_dual_function_pin_oe = (pin_mode_reg == SPSL_PIN_DOUT); // (R7)
  assign o_pwm_clock_tick       = tick_reg;
  assign o_shutdown             = shutdown_reg;
  assign o_io_ports_hiz         = hiz_reg;

  // Checks

  a_shift_on_rise: assert property (@(posedge i_clock) disable iff (i_sys_rst) // (R1)
    sclk_rise && !cs_n_s |=> shift_reg == {$past(shift_reg[WORD_BITS-2:0]), $past(din_s)})
    else $error("shift register did not take data on serial clock rise");

  a_hold_cs_high: assert property (@(posedge i_clock) disable iff (i_sys_rst) // (R3)
    cs_n_s |=> shift_reg == $past(shift_reg) && dout_reg == $past(dout_reg))
    else $error("serial state changed while chip select high");

  a_dout_only_fall: assert property (@(posedge i_clock) disable iff (i_sys_rst) // (R2)
    !(sclk_fall && !cs_n_s) |=> $stable(dout_reg))
    else $error("data output changed outside a falling edge");

  a_dout_top_bit: assert property (@(posedge i_clock) disable iff (i_sys_rst) // (R5)
    sclk_fall && !cs_n_s |=> dout_reg == $past(shift_reg[WORD_BITS-1]))
    else $error("data output is not the oldest shifted bit");

  a_cmd_latch: assert property (@(posedge i_clock) disable iff (i_sys_rst) // (R4)
    cs_rise && fifo_in_ready && !o_cmd_valid |=> o_cmd_valid && fifo_out_data == $past(shift_reg))
    else $error("latched command differs from shift register");

  a_one_per_cs: assert property (@(posedge i_clock) disable iff (i_sys_rst) // (R13)
    cs_rise && fifo_in_ready && !cmd_fire
    |=> u_fifo.count_reg == $past(u_fifo.count_reg) + 1'b1)
    else $error("chip select rise did not queue exactly one command");

  a_full_drop: assert property (@(posedge i_clock) disable iff (i_sys_rst) // (R13)
    cs_rise && !fifo_in_ready && !cmd_fire |=> $stable(u_fifo.count_reg))
    else $error("word queued although command queue was full");

  a_cmd_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst) // (R13)
    o_cmd_valid && !i_cmd_ready |=> o_cmd_valid && $stable(o_cmd))
    else $error("queued command changed before it was accepted");

  a_pin_mode_cause: assert property (@(posedge i_clock) disable iff (i_sys_rst) // (R7)
    $changed(o_dual_function_pin_oe) |-> $past(cfg_write))
    else $error("pin function changed without config write");

  a_reset_pin_mode: assert property (@(posedge i_clock) // (R8)
    $past(i_sys_rst) && !i_sys_rst |-> o_dual_function_pin_oe == !OSC_DEFAULT)
    else $error("wrong power-up pin function");

  a_reset_state: assert property (@(posedge i_clock) // (R9) (R10)
    $past(i_sys_rst) && !i_sys_rst |-> o_shutdown && (&o_io_ports_hiz))
    else $error("power-up not in shutdown with ports high impedance");

  a_hiz_cause: assert property (@(posedge i_clock) disable iff (i_sys_rst) // (R9)
    $changed(o_io_ports_hiz) |-> $past(cmd_fire) && !$past(o_cmd.rd))
    else $error("port left high impedance without a write");

  a_run_bit: assert property (@(posedge i_clock) disable iff (i_sys_rst) // (R12)
    cfg_write |=> o_shutdown == !$past(o_cmd.data[`SPSL_CFG_RUN_BIT]))
    else $error("shutdown does not follow run bit");

  // A tick may only come from a rise seen while the pin was an input
  a_tick_mode: assert property (@(posedge i_clock) disable iff (i_sys_rst) // (R7)
    o_pwm_clock_tick |-> $past(pin_mode_reg) == SPSL_PIN_OSC)
    else $error("PWM clock tick outside clock input mode");

  a_shutdown_cause: assert property (@(posedge i_clock) disable iff (i_sys_rst) // (R12)
    $changed(o_shutdown) |-> $past(cfg_write))
    else $error("shutdown changed without config write");

  c_cs_rise: cover property (@(posedge i_clock) disable iff (i_sys_rst) cs_rise);
  c_leave_shutdown: cover property (@(posedge i_clock) disable iff (i_sys_rst)
    cfg_write ##1 !o_shutdown);
  c_fifo_full: cover property (@(posedge i_clock) disable iff (i_sys_rst) !fifo_in_ready);
  c_osc_tick: cover property (@(posedge i_clock) disable iff (i_sys_rst) o_pwm_clock_tick);
  c_fifo_drop: cover property (@(posedge i_clock) disable iff (i_sys_rst)
    cs_rise && !fifo_in_ready);

endmodule : spsl_top

/* File: testbench/spsl_host_model.sv */
module spsl_host_model (
  input  wire logic        i_clock,
  input  wire logic        i_dout,
  output logic             o_sclk,
  output logic             o_cs_n,
  output logic             o_din,
  output logic [31:0]      o_rx
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_sclk = 1'h0;
    o_cs_n = 1'h1;
    o_din  = 1'h0;
    o_rx   = 32'h0;
  end

  // Half of a 320 ns serial period, always ending on a falling system edge
  task automatic half();
    repeat (4) @(negedge i_clock);
  endtask : half

  // Serial clock runs only inside the frame; the oldest 16 bits fall away
  task automatic send(input logic [31:0] bits);
    o_cs_n = 1'h0;
    half();
    for (int i = 31; i >= 0; i--) begin
      o_din = bits[i];
      half();
      o_sclk = 1'h1;
      o_rx = {o_rx[30:0], i_dout};
      half();
      o_sclk = 1'h0;
    end
    half();
    o_cs_n = 1'h1;
    // Data line left floating: show the inverse rather than a stale bit
    o_din = ~o_din;
    half();
  endtask : send

  // Stray pulses while deselected
  task automatic stray();
    for (int i = 0; i < 8; i++) begin
      o_din = ~o_din;
      half();
      o_sclk = 1'h1;
      half();
      o_sclk = 1'h0;
    end
  endtask : stray
endmodule : spsl_host_model

/* File: testbench/tb_spsl_top.sv */
module tb_spsl_top;
  import spsl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clock;
  logic        i_sys_rst;
  logic        i_cmd_ready;
  logic        pin_in;
  logic        sclk;
  logic        cs_n;
  logic        din;
  logic        dout;
  logic        oe;
  logic        tick;
  logic        valid;
  logic        room;
  logic        shutdown;
  logic [9:0]  hiz;
  logic [31:0] rx;
  logic [15:0] n;
  spsl_cmd_t   cmd;
  int          bad_count;
  int          n_checks;
  int          cycles;

  spsl_top #(.OSC_DEFAULT(1'h0)) uut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
    .i_dual_function_pin(pin_in), .o_dual_function_pin(dout), .o_dual_function_pin_oe(oe),
    .o_pwm_clock_tick(tick), .o_cmd_valid(valid), .i_cmd_ready(i_cmd_ready), .o_cmd(cmd),
    .o_cmd_room(room), .o_shutdown(shutdown), .o_io_ports_hiz(hiz)
  );

  spsl_host_model host (
    .i_clock(i_clock), .i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .o_rx(rx)
  );

  initial begin
    i_clock = 1'h0;
    forever #20 i_clock = ~i_clock;
  end

  // Whole run is about 7000 cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic push(input logic [31:0] bits);
    int k;
    k = 0;
    host.send(bits);
    while (valid !== 1'h1 && k < 40) begin
      @(negedge i_clock);
      k++;
    end
  endtask : push

  task automatic accept();
    i_cmd_ready = 1'h1;
    @(negedge i_clock);
    i_cmd_ready = 1'h0;
    repeat (2) @(negedge i_clock);
  endtask : accept

  task automatic t_reset();
    chk("oe", 16'h1, oe);
    chk("shutdown", 16'h1, shutdown);
    chk("hiz", 16'h3FF, hiz);
    chk("valid", 16'h0, valid);
    chk("room", 16'h1, room);
  endtask : t_reset

  task automatic t_run();
    push(32'hA5C3_1001);
    chk("cmd", 16'h1001, cmd);
    chk("readback", 16'hA5C3, rx[15:0]);
    accept();
    chk("shutdown", 16'h0, shutdown);
    chk("valid", 16'h0, valid);
    push(32'h5A3C_1000);
    chk("readback", 16'h5A3C, rx[15:0]);
    accept();
    chk("shutdown", 16'h1, shutdown);
  endtask : t_run

  task automatic t_port();
    push(32'h0000_0305);
    accept();
    chk("hiz", 16'h3F7, hiz);
  endtask : t_port

  // Stray pulses must leave the shift register holding the last word
  task automatic t_stray();
    host.stray();
    push(32'h1234_0001);
    chk("stale", 16'h0305, rx[31:16]);
    chk("cmd", 16'h0001, cmd);
    accept();
    chk("hiz", 16'h3F6, hiz);
  endtask : t_stray

  task automatic t_osc();
    push(32'h0000_1003);
    accept();
    chk("oe", 16'h0, oe);
    n = 16'h0;
    // Two periods of a 100 kHz square wave, the fastest the host may apply
    repeat (2) begin
      pin_in = 1'h1;
      repeat (125) begin
        @(negedge i_clock);
        n += tick;
      end
      pin_in = 1'h0;
      repeat (125) begin
        @(negedge i_clock);
        n += tick;
      end
    end
    chk("ticks", 16'h2, n);
    push(32'h0000_1001);
    accept();
    chk("oe", 16'h1, oe);
    // Back in output mode a rise on the pin must not tick
    n = 16'h0;
    pin_in = 1'h1;
    repeat (10) begin
      @(negedge i_clock);
      n += tick;
    end
    pin_in = 1'h0;
    chk("ticks dout", 16'h0, n);
  endtask : t_osc

  task automatic t_fifo();
    for (int i = 0; i < 16; i++)
      push({24'h000001, i[7:0]});
    chk("room", 16'h0, room);
    push(32'h0000_01FF);
    for (int i = 0; i < 16; i++) begin
      chk("fifo", {8'h01, i[7:0]}, cmd);
      accept();
    end
    chk("valid", 16'h0, valid);
  endtask : t_fifo

  // Reset in mid-run, after ports and run were programmed, restores power-up state
  task automatic t_rerun();
    chk("hiz", 16'h3F4, hiz);
    chk("shutdown", 16'h0, shutdown);
    i_sys_rst = 1'h1;
    repeat (4) @(negedge i_clock);
    i_sys_rst = 1'h0;
    repeat (3) @(negedge i_clock);
    t_reset();
  endtask : t_rerun

  initial begin
    i_sys_rst   = 1'h1;
    i_cmd_ready = 1'h0;
    pin_in      = 1'h0;
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    i_sys_rst = 1'h0;
    repeat (3) @(negedge i_clock);
    t_reset();
    t_run();
    t_port();
    t_stray();
    t_osc();
    t_fifo();
    t_rerun();
    complete_run();
  end
endmodule : tb_spsl_top
